// >>> pkg/bmf_pkg.sv
`default_nettype none
package bmf_pkg;
   // Frame layout
   localparam logic [7:0]  START0      = 8'hC1;
   localparam logic [7:0]  START1      = 8'hC0;
   localparam logic [15:0] PROTO_VER   = 16'h1000;
   localparam logic [31:0] FOOTER      = 32'hC5C4C3C2;
   localparam logic [31:0] TRAILER_LEN = 32'h00000014;
   localparam logic [7:0]  CK_NONE     = 8'h00;
   localparam logic [7:0]  CK_MD5      = 8'h01;
   localparam logic [7:0]  IMM_MAX     = 8'h10;
   localparam logic [5:0]  OFS_VER     = 6'h02;
   localparam logic [5:0]  OFS_FLAGS   = 6'h04;
   localparam logic [5:0]  OFS_ERR     = 6'h06;
   localparam logic [5:0]  OFS_TYPE    = 6'h08;
   localparam logic [5:0]  OFS_TAG     = 6'h0C;
   localparam logic [5:0]  OFS_RSV     = 6'h10;
   localparam logic [5:0]  OFS_CKT     = 6'h16;
   localparam logic [5:0]  OFS_IMMLEN  = 6'h17;
   localparam logic [5:0]  OFS_IMM     = 6'h18;
   localparam logic [5:0]  OFS_REM     = 6'h28;
   localparam logic [5:0]  OFS_CKSUM   = 6'h2C;
   localparam logic [5:0]  OFS_FOOT    = 6'h3C;
   localparam logic [5:0]  HDR_LAST    = 6'h2B;
   localparam logic [5:0]  CK_LAST     = 6'h0F;
   localparam logic [5:0]  FT_LAST     = 6'h03;
   localparam logic [5:0]  TX_LAST     = 6'h3F;
   // Flag bits
   localparam int FLG_RESP   = 0;
   localparam int FLG_ACK    = 1;
   localparam int FLG_ACKREQ = 2;
   localparam int FLG_NACK   = 3;
   localparam int FLG_EXC    = 4;
   // Device error numbers
   localparam logic [15:0] ERR_NOT_READY = 16'h0007;
   localparam logic [15:0] ERR_CK_TYPE   = 16'h0008;
   localparam logic [15:0] ERR_DEV_RESET = 16'h0009;
   // Register byte addresses
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_TYPE     = 8'h04;
   localparam logic [7:0] REG_TAG      = 8'h08;
   localparam logic [7:0] REG_IMMLEN   = 8'h0C;
   localparam logic [7:0] REG_IMM0     = 8'h10;
   localparam logic [7:0] REG_STAT     = 8'h20;
   localparam logic [7:0] REG_RXTYPE   = 8'h24;
   localparam logic [7:0] REG_RXTAG    = 8'h28;
   localparam logic [7:0] REG_RXFLAG   = 8'h2C;
   localparam logic [7:0] REG_RXCK     = 8'h30;
   localparam logic [7:0] REG_RXIMM0   = 8'h34;
   localparam logic [7:0] REG_RXPAYLEN = 8'h44;
   localparam logic [1:0] AXI_OKAY     = 2'h0;
   localparam logic [1:0] AXI_SLVERR   = 2'h2;
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} bmf_tx_e;
   typedef enum logic [1:0] {RX_HDR = 2'b00, RX_PAY = 2'b01, RX_CK = 2'b10,
                             RX_FT = 2'b11} bmf_rx_e;
endpackage
`default_nettype wire

// >>> src/bmf_host_framer.sv
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module bmf_host_framer
   import bmf_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [7:0]       txData,
   output logic             txValid,
   input  wire logic        txReady,
   input  wire logic [7:0]  rxData,
   input  wire logic        rxValid,
   output logic             rxReady,
   output logic [7:0]       rxPayData,
   output logic             rxPayValid
);
   ////////////////////////////////////////////////////////////////////////////////
   bmf_tx_e      txState, next_txState;
   logic [5:0]   txIdx, next_txIdx;
   logic [7:0]   next_txData;
   logic         next_txValid;
   logic [31:0]  typeReg, next_typeReg, tagReg, next_tagReg;
   logic [7:0]   immLen, next_immLen;
   logic [127:0] immReg, next_immReg;
   logic         ackReq, next_ackReq;
   logic         txGo;
   bmf_rx_e      rxState, next_rxState;
   logic [5:0]   rxIdx, next_rxIdx;
   logic [31:0]  rxCnt, next_rxCnt, rxPayLen, next_rxPayLen, rxRem;
   logic [7:0]   rxHdr [44];
   logic         hdrWr, rxTake, frameEnd;
   logic         rxDone, next_rxDone, rxErr, next_rxErr, footBad, next_footBad;
   logic [3:0]   rxFault, next_rxFault;
   logic         next_rxPayValid;
   logic [7:0]   next_rxPayData;
   logic         next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]   next_bresp, next_rresp;
   logic [31:0]  next_rdata;
   logic         wrEn, stClr;

   function automatic logic [31:0] bmfMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] bmfHdrWord(input logic [5:0] b);
      return {rxHdr[b + 6'h03], rxHdr[b + 6'h02], rxHdr[b + 6'h01], rxHdr[b]};
   endfunction

   // Byte of the outgoing request frame at position idx
   function automatic logic [7:0] bmfTxByte(input logic [5:0] idx);
      logic [7:0] b;
      logic [5:0] rel;
      b   = 8'h00;
      rel = idx - OFS_IMM;
      if (idx == 6'h00)
         b = START0;
      else if (idx == 6'h01)
         b = START1;
      else if (idx < OFS_FLAGS)
         b = PROTO_VER[{idx[0], 3'b000} +: 8];
      else if (idx == OFS_FLAGS)
         b = {5'h00, ackReq, 2'h0};
      else if (idx >= OFS_TYPE && idx < OFS_TAG)
         b = typeReg[{idx[1:0], 3'b000} +: 8];
      else if (idx >= OFS_TAG && idx < OFS_RSV)
         b = tagReg[{idx[1:0], 3'b000} +: 8];
      // No checksum computed, block left zero
      else if (idx == OFS_CKT)
         b = CK_NONE;
      else if (idx == OFS_IMMLEN)
         b = immLen;
      else if (idx >= OFS_IMM && idx < OFS_REM)
         b = immReg[{rel[3:0], 3'b000} +: 8];
      else if (idx == OFS_REM)
         b = TRAILER_LEN[7:0];
      else if (idx >= OFS_FOOT)
         b = FOOTER[{2'(TX_LAST - idx), 3'b000} +: 8];
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register slave
   assign wrEn  = s_axi_awready;
   assign stClr = wrEn && s_axi_awaddr == REG_STAT && s_axi_wstrb[0];
   assign txGo  = wrEn && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0] && s_axi_wdata[0]
                  && txState == TX_IDLE;

   always_comb
   begin
      next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      next_wready  = next_awready;
      next_bvalid  = s_axi_bvalid && !s_axi_bready;
      next_bresp   = s_axi_bresp;
      next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      next_rvalid  = s_axi_rvalid && !s_axi_rready;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      next_typeReg = typeReg;
      next_tagReg  = tagReg;
      next_immLen  = immLen;
      next_immReg  = immReg;
      next_ackReq  = ackReq;
      if (wrEn)
      begin
         next_bvalid = 1'b1;
         next_bresp  = AXI_OKAY;
         if (txState == TX_SEND && s_axi_awaddr < REG_STAT)
            next_bresp = AXI_SLVERR;
         else if (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0])
            next_ackReq = s_axi_wdata[FLG_ACKREQ];
         else if (s_axi_awaddr == REG_TYPE)
            next_typeReg = bmfMerge(typeReg, s_axi_wdata, s_axi_wstrb);
         else if (s_axi_awaddr == REG_TAG)
            next_tagReg = bmfMerge(tagReg, s_axi_wdata, s_axi_wstrb);
         else if (s_axi_awaddr == REG_IMMLEN && s_axi_wstrb[0])
            next_immLen = (s_axi_wdata[7:0] > IMM_MAX) ? IMM_MAX : s_axi_wdata[7:0];
         else if (s_axi_awaddr >= REG_IMM0 && s_axi_awaddr < REG_STAT
                  && s_axi_awaddr[1:0] == 2'b00)
            next_immReg[{s_axi_awaddr[3:2], 5'h00} +: 32] =
               bmfMerge(immReg[{s_axi_awaddr[3:2], 5'h00} +: 32], s_axi_wdata, s_axi_wstrb);
         else if (s_axi_awaddr != REG_STAT)
            next_bresp = AXI_SLVERR;
      end
      if (s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = AXI_OKAY;
         next_rdata  = 32'h00000000;
         case (s_axi_araddr)
            REG_CTRL:     next_rdata = {29'h0, ackReq, 1'b0, txState == TX_SEND};
            REG_TYPE:     next_rdata = typeReg;
            REG_TAG:      next_rdata = tagReg;
            REG_IMMLEN:   next_rdata = {24'h0, immLen};
            REG_STAT:     next_rdata = {24'h0, rxFault, rxState != RX_HDR || rxIdx != 6'h00,
                                        rxErr, rxDone, txState == TX_SEND};
            REG_RXTYPE:   next_rdata = bmfHdrWord(OFS_TYPE);
            REG_RXTAG:    next_rdata = bmfHdrWord(OFS_TAG);
            REG_RXFLAG:   next_rdata = bmfHdrWord(OFS_FLAGS);
            // Immediate length hidden when payload present
            REG_RXCK:     next_rdata = {16'h0, rxHdr[OFS_CKT],
                                        (rxPayLen != 32'h0) ? 8'h00 : rxHdr[OFS_IMMLEN]};
            REG_RXPAYLEN: next_rdata = rxPayLen;
            default:
            begin
               // Immediate area readable beside the payload stream
               if (s_axi_araddr >= REG_IMM0 && s_axi_araddr < REG_STAT
                   && s_axi_araddr[1:0] == 2'b00)
                  next_rdata = immReg[{s_axi_araddr[3:2], 5'h00} +: 32];
               else if (s_axi_araddr >= REG_RXIMM0 && s_axi_araddr < REG_RXPAYLEN
                        && s_axi_araddr[1:0] == 2'b00)
                  next_rdata = bmfHdrWord(6'(s_axi_araddr - REG_RXIMM0) + OFS_IMM);
               else
                  next_rresp = AXI_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= AXI_OKAY;
         s_axi_rdata   <= 32'h00000000;
         typeReg       <= 32'h00000000;
         tagReg        <= 32'h00000000;
         immLen        <= 8'h00;
         immReg        <= '0;
         ackReq        <= 1'b0;
      end
      else
      begin
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
         typeReg       <= next_typeReg;
         tagReg        <= next_tagReg;
         immLen        <= next_immLen;
         immReg        <= next_immReg;
         ackReq        <= next_ackReq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request sender; immediate data only, so remaining count is fixed
   always_comb
   begin
      next_txState = txState;
      next_txIdx   = txIdx;
      next_txValid = txValid;
      next_txData  = txData;
      case (txState)
         TX_IDLE:
            if (txGo)
            begin
               next_txState = TX_SEND;
               next_txIdx   = 6'h00;
               next_txValid = 1'b1;
               next_txData  = bmfTxByte(6'h00);
            end
         TX_SEND:
            if (txValid && txReady)
            begin
               if (txIdx == TX_LAST)
               begin
                  next_txState = TX_IDLE;
                  next_txValid = 1'b0;
               end
               else
               begin
                  next_txIdx  = txIdx + 6'h01;
                  next_txData = bmfTxByte(txIdx + 6'h01);
               end
            end
         default:
            next_txState = TX_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txState <= TX_IDLE;
         txIdx   <= 6'h00;
         txValid <= 1'b0;
         txData  <= 8'h00;
      end
      else
      begin
         txState <= next_txState;
         txIdx   <= next_txIdx;
         txValid <= next_txValid;
         txData  <= next_txData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response parser
   assign rxTake   = rxValid && rxReady;
   assign rxRem    = {rxData, rxHdr[OFS_REM + 6'h02], rxHdr[OFS_REM + 6'h01], rxHdr[OFS_REM]};
   assign frameEnd = rxTake && rxState == RX_FT && rxIdx == FT_LAST;

   always_comb
   begin
      next_rxState    = rxState;
      next_rxIdx      = rxIdx;
      next_rxCnt      = rxCnt;
      next_rxPayLen   = rxPayLen;
      next_footBad    = footBad;
      next_rxFault    = rxFault;
      next_rxPayValid = 1'b0;
      next_rxPayData  = rxPayData;
      next_rxDone     = rxDone && !(stClr && s_axi_wdata[1]);
      next_rxErr      = rxErr && !(stClr && s_axi_wdata[2]);
      hdrWr           = 1'b0;
      case (rxState)
         RX_HDR:
            if (rxTake)
            begin
               hdrWr      = 1'b1;
               next_rxIdx = rxIdx + 6'h01;
               if (rxIdx == 6'h00 && rxData != START0)
                  next_rxIdx = 6'h00;
               else if (rxIdx == 6'h01 && rxData != START1)
                  next_rxIdx = 6'h00;
               else if (rxIdx == HDR_LAST)
               begin
                  next_rxIdx   = 6'h00;
                  next_footBad = 1'b0;
                  // Body length taken from the header
                  if (rxRem < TRAILER_LEN)
                  begin
                     next_rxFault = 4'h8;
                     next_rxDone  = 1'b1;
                     next_rxErr   = 1'b1;
                  end
                  else
                  begin
                     next_rxPayLen = rxRem - TRAILER_LEN;
                     next_rxCnt    = rxRem - TRAILER_LEN;
                     next_rxState  = (rxRem == TRAILER_LEN) ? RX_CK : RX_PAY;
                  end
               end
            end
         RX_PAY:
            if (rxTake)
            begin
               next_rxPayValid = 1'b1;
               next_rxPayData  = rxData;
               next_rxCnt      = rxCnt - 32'h1;
               if (rxCnt == 32'h1)
                  next_rxState = RX_CK;
            end
         RX_CK:
            // Checksum block follows body; contents not verified
            if (rxTake)
            begin
               next_rxIdx = rxIdx + 6'h01;
               if (rxIdx == CK_LAST)
               begin
                  next_rxIdx   = 6'h00;
                  next_rxState = RX_FT;
               end
            end
         RX_FT:
            if (rxTake)
            begin
               next_rxIdx = rxIdx + 6'h01;
               if (rxData != FOOTER[{2'(FT_LAST - rxIdx), 3'b000} +: 8])
                  next_footBad = 1'b1;
               if (rxIdx == FT_LAST)
               begin
                  next_rxIdx   = 6'h00;
                  next_rxState = RX_HDR;
                  next_rxFault = {1'b0, rxHdr[OFS_CKT] > CK_MD5, next_footBad,
                                  {rxHdr[OFS_VER + 6'h01], rxHdr[OFS_VER]} != PROTO_VER};
                  next_rxDone  = 1'b1;
                  next_rxErr   = rxErr || next_rxFault != 4'h0;
               end
            end
         default:
            next_rxState = RX_HDR;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (hdrWr)
         rxHdr[rxIdx] <= rxData;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rxState    <= RX_HDR;
         rxIdx      <= 6'h00;
         rxCnt      <= 32'h0;
         rxPayLen   <= 32'h0;
         footBad    <= 1'b0;
         rxFault    <= 4'h0;
         rxDone     <= 1'b0;
         rxErr      <= 1'b0;
         rxPayValid <= 1'b0;
         rxPayData  <= 8'h00;
         rxReady    <= 1'b0;
      end
      else
      begin
         rxState    <= next_rxState;
         rxIdx      <= next_rxIdx;
         rxCnt      <= next_rxCnt;
         rxPayLen   <= next_rxPayLen;
         footBad    <= next_footBad;
         rxFault    <= next_rxFault;
         rxDone     <= next_rxDone;
         rxErr      <= next_rxErr;
         rxPayValid <= next_rxPayValid;
         rxPayData  <= next_rxPayData;
         rxReady    <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence sTxAt(logic [5:0] pos);
      txValid && txIdx == pos;
   endsequence
   sequence sFootStart;
      txValid && txReady && txIdx == 6'h3B;
   endsequence

   a_tx_start_mark: assert property (sTxAt(6'h00) |-> txData == START0)
      else $error("first byte is not start marker");
   a_tx_version: assert property (sTxAt(6'h03) |-> txData == PROTO_VER[15:8])
      else $error("version high byte wrong");
   a_tx_type_le: assert property (sTxAt(6'h08) |-> txData == typeReg[7:0])
      else $error("message type low byte not first");
   a_tx_reserved: assert property (txValid && txIdx >= OFS_RSV && txIdx < OFS_CKT
                                   |-> txData == 8'h00)
      else $error("reserved byte not zero");
   a_tx_remaining: assert property (sTxAt(6'h28) |-> txData == TRAILER_LEN[7:0])
      else $error("remaining count wrong");
   a_tx_footer_seq: assert property (sFootStart |=> txData == 8'hC5 && txIdx == 6'h3C)
      else $error("footer does not start with C5");
   a_imm_len_max: assert property (immLen <= IMM_MAX)
      else $error("immediate length above limit");
   a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("byte changed before taken");
   a_rx_pay_len: assert property (rxTake && rxState == RX_HDR && rxIdx == HDR_LAST
                                  && rxRem >= TRAILER_LEN
                                  |=> rxPayLen == $past(rxRem) - TRAILER_LEN)
      else $error("payload length not remaining minus 20");
   a_rx_done_end: assert property (frameEnd |=> rxDone && rxState == RX_HDR)
      else $error("frame end not reported");
endmodule
`default_nettype wire

// >>> tb/bmf_device_model.sv
`timescale 1ns/1ns
`default_nettype none
module bmf_device_model
   import bmf_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   output logic            txReady,
   output logic [7:0]      rxData,
   output logic            rxValid,
   input  wire logic       rxReady,
   input  wire logic [7:0] payLen,
   input  wire logic [7:0] ckType,
   input  wire logic       slow
);
   logic [7:0] req [0:63];
   logic [7:0] rsp [0:127];
   int         nReq, nRsp, rspLen, i;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         txReady <= 1'b0;
         rxValid <= 1'b0;
         rxData  <= 8'h00;
         nReq = 0;
         nRsp = 0;
         rspLen = 0;
      end
      else
      begin
         txReady <= slow ? ~txReady : 1'b1;
         if (txValid && txReady)
         begin
            req[nReq] = txData;
            nReq++;
         end
         if (nReq == 64)
         begin
            for (i = 0; i < 44; i++)
               rsp[i] = ((i >= 8 && i < 16) || (i >= 23 && i < 40)) ? req[i] : 8'h00;
            rsp[0] = START0;
            rsp[1] = START1;
            rsp[2] = PROTO_VER[7:0];
            rsp[3] = PROTO_VER[15:8];
            rsp[4] = 8'h01;
            if (ckType > CK_MD5)
            begin
               rsp[4] = 8'h09;
               rsp[6] = ERR_CK_TYPE[7:0];
            end
            rsp[22] = ckType;
            rsp[40] = payLen + 8'h14;
            for (i = 0; i < payLen + 20; i++)
               rsp[44 + i] = (i < payLen) ? 8'h30 + 8'(i) : 8'h00;
            for (i = 0; i < 4; i++)
               rsp[60 + payLen + i] = FOOTER[31 - 8 * i -: 8];
            rspLen = 64 + payLen;
            nRsp = 0;
            nReq = 0;
         end
         if (rxValid && rxReady)
            nRsp++;
         // Idle line toggles so stale data never looks valid
         rxValid <= nRsp < rspLen;
         rxData  <= (nRsp < rspLen) ? rsp[nRsp] : ~rxData;
      end
   end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h, expected %h", $time, a, b); end end
module testbench
   import bmf_pkg::*;
;
   logic        mclk = 1'b0, reset_n = 1'b0, awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0;
   logic        rR = 1'b0, slow = 1'b0;
   logic [7:0]  awA = 8'h00, arA = 8'h00, payLen = 8'h00, ckType = 8'h00;
   logic [31:0] wD = 32'h0, rD, d;
   logic [1:0]  bResp, rResp, r;
   logic        awRdy, wRdy, bV, arRdy, rV, txValid, txReady, rxValid, rxReady, rxPayValid;
   logic [7:0]  txData, rxData, rxPayData;
   int          checks = 0, mismatches = 0, cyc = 0, payCnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   bmf_host_framer DUT (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awA),
      .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
      .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
      .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
      .rxValid(rxValid), .rxReady(rxReady), .rxPayData(rxPayData), .rxPayValid(rxPayValid));
   bmf_device_model dev (.mclk(mclk), .reset_n(reset_n), .txData(txData),
      .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
      .rxReady(rxReady), .payLen(payLen), .ckType(ckType), .slow(slow));
   ////////////////////////////////////////////////////////////////////////////////
   initial
      forever #2 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (rxPayValid === 1'b1)
      begin
         `CHK(rxPayData, 8'h30 + payCnt[7:0])
         payCnt++;
      end
      if (cyc == 20000)
      begin
         mismatches++;
         results;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic axWr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] res);
      bit done = 0;
      @(posedge mclk);
      awA <= a;
      wD <= v;
      awV <= 1'b1;
      wV <= 1'b1;
      bR <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (awRdy === 1'b1) awV <= 1'b0;
         if (wRdy === 1'b1) wV <= 1'b0;
         if (bV === 1'b1)
         begin
            res = bResp;
            bR <= 1'b0;
            done = 1;
         end
      end
   endtask
   task automatic axRd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] res);
      bit done = 0;
      @(posedge mclk);
      arA <= a;
      arV <= 1'b1;
      rR <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (arRdy === 1'b1) arV <= 1'b0;
         if (rV === 1'b1)
         begin
            v = rD;
            res = rResp;
            rR <= 1'b0;
            done = 1;
         end
      end
   endtask
   // Sends one immediate-data request, answers it, checks both frames
   task automatic exchange(input logic [7:0] pl, input logic [7:0] ck, input logic sl);
      payLen <= pl;
      ckType <= ck;
      slow <= sl;
      payCnt = 0;
      axWr(REG_TYPE, 32'h00110010, r);
      axWr(REG_TAG, 32'hA5C35A3C, r);
      axWr(REG_IMMLEN, 32'h4, r);
      axWr(REG_IMM0, 32'h11223344, r);
      axWr(REG_CTRL, {29'h0, sl, 2'b01}, r);
      `CHK(r, AXI_OKAY)
      axWr(REG_TYPE, 32'h0, r);
      `CHK(r, AXI_SLVERR)
      do axRd(REG_STAT, d, r); while (d[1] !== 1'b1);
      `CHK(d[7:4], {1'b0, ck > 8'h01, 2'b00})
      `CHK({dev.req[1], dev.req[0]}, {START1, START0})
      `CHK({dev.req[3], dev.req[2]}, PROTO_VER)
      `CHK({dev.req[7], dev.req[6], dev.req[5], dev.req[4]}, {29'h0, sl, 2'b00})
      `CHK({dev.req[11], dev.req[10], dev.req[9], dev.req[8]}, 32'h00110010)
      `CHK({dev.req[15], dev.req[14], dev.req[13], dev.req[12]}, 32'hA5C35A3C)
      `CHK({dev.req[22], dev.req[23], dev.req[24]}, 24'h000444)
      `CHK({dev.req[43], dev.req[42], dev.req[41], dev.req[40]}, TRAILER_LEN)
      `CHK({dev.req[60], dev.req[61], dev.req[62], dev.req[63]}, FOOTER)
      for (int i = 16; i < 60; i++)
         if (i < 22 || i > 43) `CHK(dev.req[i], 8'h00)
      axRd(REG_RXTAG, d, r);
      `CHK(d, 32'hA5C35A3C)
      axRd(REG_RXFLAG, d, r);
      `CHK(d, (ck > 8'h01) ? {ERR_CK_TYPE, 16'h0009} : 32'h1)
      axRd(REG_RXPAYLEN, d, r);
      `CHK(d, {24'h0, pl})
      axRd(REG_RXCK, d, r);
      `CHK(d[15:0], {ck, (pl == 8'h00) ? 8'h04 : 8'h00})
      axRd(REG_RXIMM0, d, r);
      `CHK(d, 32'h11223344)
      axRd(REG_CTRL, d, r);
      `CHK(d, {29'h0, sl, 2'b00})
      `CHK(payCnt, int'(pl))
      axWr(REG_STAT, 32'h6, r);
      $display("test done: payload %0d, checksum type %0d", pl, ck);
   endtask
   // Read of an unmapped address is refused with zero data
   task automatic unmappedRead;
      axRd(8'h80, d, r);
      `CHK({r, d}, {AXI_SLVERR, 32'h0})
      $display("test done: unmapped read");
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      exchange(8'd0, CK_NONE, 1'b0);
      exchange(8'd5, CK_MD5, 1'b1);
      exchange(8'd2, 8'h02, 1'b0);
      unmappedRead;
      results;
   end
endmodule
`default_nettype wire
